/* hdl/tcw_pkg.sv */
// Summary of operation
// [RQ1] A count write blocks every compare match in the next timer clock cycle.
// [RQ2] Software avoids writing a count equal to a compare value while in use.
// [RQ3] The output latch keeps its level when the waveform mode changes.
// [RQ4] Output mode bits are unbuffered and act from the next compare match.
// [RQ5] In non-PWM modes a force strobe applies the output action at once.
// [RQ6] A nonzero output mode puts the latch on the pin; direction stays external.
// [RQ7] Output mode zero leaves the latch untouched on compare matches.
// [RQ8] Only the waveform mode decides how the counter counts.
// [RQ9] Mode 0 counts up, wraps 0xFF to 0x00, never clears.
// [RQ10] In normal mode overflow is flagged as the count becomes zero.
// [RQ11] Mode 2 clears the counter on a match with compare value A.
// [RQ12] Clear-on-match writes compare A directly; a low value waits for a wrap.
// [RQ13] Clear-on-match with output mode 1 toggles output A on each match.
// [RQ14] Clear-on-match flags overflow as the count passes from 0xFF to 0x00.
// [RQ15] Modes 3 and 7 are fast PWM, top 0xFF or compare value A.
// [RQ16] In fast PWM the counter returns to zero the tick after top.
// [RQ17] Fast PWM mode 2 clears on match, sets at restart; mode 3 inverts.
// [RQ18] Fast PWM flags overflow each time the counter reaches top.
// [RQ19] Fast PWM compare writes go to the buffer, not the active comparator.
// [RQ20] Fast PWM output mode 1 toggles output A on each match.
// [RQ21] Fast PWM compare zero gives a spike, compare max a constant level.
// [RQ22] A match sets its compare flag on the next tick; ack or write one clears.
// [RQ23] A force moves only the latch, never a flag or the counter.
// [RQ24] In PWM modes the buffer reaches the comparator only at top.
// [RQ25] After reset the latches and output modes are zero.
package tcw_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [3:0] TCW_CTRL_OFF = 4'h0;
  localparam logic [3:0] TCW_FORCE_OFF = 4'h1;
  localparam logic [3:0] TCW_COUNT_OFF = 4'h2;
  localparam logic [3:0] TCW_CMPA_OFF = 4'h3;
  localparam logic [3:0] TCW_CMPB_OFF = 4'h4;
  localparam logic [3:0] TCW_FLAG_OFF = 4'h5;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int TCW_WM_LSB = 0;
  localparam int TCW_MODE_B_LSB = 4;
  localparam int TCW_MODE_A_LSB = 6;
  localparam int TCW_OVF_BIT = 0;
  localparam int TCW_CMP_BIT0 = 1;
  localparam int TCW_CHANNELS = 2;
  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [7:0] TCW_BYTE_RST = 8'h00;
  localparam logic TCW_BIT_RST = 1'b0;
  localparam logic [2:0] TCW_WM_NORMAL = 3'h0;
  localparam logic [2:0] TCW_WM_CLEAR_ON_MATCH = 3'h2;
  localparam logic [2:0] TCW_WM_FAST_MAX = 3'h3;
  localparam logic [2:0] TCW_WM_FAST_CMP = 3'h7;
  localparam logic [7:0] TCW_COUNT_MAX = 8'hFF;
  localparam logic [7:0] TCW_COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] TCW_COUNT_STEP = 8'h01;
  localparam logic [1:0] TCW_OM_OFF = 2'h0;
  localparam logic [1:0] TCW_OM_TOGGLE = 2'h1;
  localparam logic [1:0] TCW_OM_CLEAR = 2'h2;
  localparam logic [1:0] TCW_OM_SET = 2'h3;
endpackage

/* hdl/tcw_ch_if.sv */
interface tcw_ch_if;
  logic match;
  logic restart;
  logic force_strobe;
  logic pwm;
  logic ch_a;
  logic [1:0] mode;
  logic port_value;
  logic direction;
  logic latch;
  logic pin_out;
  logic pin_oe;
  modport ctl (output match, restart, force_strobe, pwm, ch_a, mode, port_value, direction,
               input latch, pin_out, pin_oe);
  modport unit (input match, restart, force_strobe, pwm, ch_a, mode, port_value, direction,
                output latch, pin_out, pin_oe);
endinterface

/* hdl/tcw_channel.sv */
module tcw_channel
  import tcw_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  tcw_ch_if.unit ch
);
  logic latch_reg;
  logic latch_next;

  // ----------------------------------------
  // Waveform latch
  // ----------------------------------------
  // Mode bits are read live, so a new setting acts on the very next event.
  always_comb
  begin
    latch_next = latch_reg;
    if (ch.pwm)
    begin
      case (ch.mode)
        TCW_OM_TOGGLE: if (ch.match && ch.ch_a) latch_next = !latch_reg; // [RQ20] [RQ4]
        // Restart wins over a match at top so a compare of max holds the level.
        TCW_OM_CLEAR: if (ch.restart) latch_next = 1'b1; else if (ch.match) latch_next = 1'b0; // [RQ17] [RQ21]
        TCW_OM_SET: if (ch.restart) latch_next = 1'b0; else if (ch.match) latch_next = 1'b1; // [RQ17]
        default: latch_next = latch_reg; // [RQ7]
      endcase
    end
    else if (ch.match || ch.force_strobe) // [RQ5] [RQ13]
    begin
      case (ch.mode)
        TCW_OM_TOGGLE: latch_next = !latch_reg;
        TCW_OM_CLEAR: latch_next = 1'b0;
        TCW_OM_SET: latch_next = 1'b1;
        default: latch_next = latch_reg; // [RQ7]
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      latch_reg <= TCW_BIT_RST; // [RQ25]
    else
      latch_reg <= latch_next; // [RQ3]
  end

  assign ch.latch = latch_reg;
  assign ch.pin_out = (ch.mode != TCW_OM_OFF) ? latch_reg : ch.port_value; // [RQ6]
  assign ch.pin_oe = ch.direction; // [RQ6]

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  latch_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ3]
    !ch.match && !ch.restart && !ch.force_strobe |=> $stable(latch_reg))
    else $error("Output latch moved without an event.");
  mode_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ7]
    ch.mode == TCW_OM_OFF |=> $stable(latch_reg))
    else $error("Output latch moved with output mode zero.");
  pin_override_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ6]
    ch.mode != TCW_OM_OFF |-> ch.pin_out == latch_reg && ch.pin_oe == ch.direction)
    else $error("Pin does not carry the compare latch.");
  force_act_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ5]
    ch.force_strobe && !ch.pwm && ch.mode == TCW_OM_TOGGLE |=> latch_reg != $past(latch_reg))
    else $error("Force strobe did not toggle the latch.");
endmodule // tcw_channel

/* hdl/tcw_timer.sv */
// The register addresses and the address-and-strobe port were left to the implementer.
module tcw_timer
  import tcw_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic timer_tick,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic flag_ack_overflow,
  input wire logic [1:0] flag_ack_compare,
  input wire logic [1:0] port_value,
  input wire logic [1:0] output_pin_direction,
  output logic [1:0] compare_output,
  output logic [1:0] compare_output_oe,
  output logic overflow_flag,
  output logic [1:0] compare_flag
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] timer_count_reg;
  logic [7:0] timer_count_next;
  logic block_reg;
  logic block_next;
  logic overflow_flag_reg;
  logic overflow_flag_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] cmp_buf_reg [TCW_CHANNELS];
  logic [7:0] cmp_buf_next [TCW_CHANNELS];
  logic [7:0] cmp_act_reg [TCW_CHANNELS];
  logic [7:0] cmp_act_next [TCW_CHANNELS];
  logic [1:0] pend_reg;
  logic [1:0] pend_next;
  logic [1:0] cmp_flag_reg;
  logic [1:0] cmp_flag_next;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic [2:0] waveform_mode;
  logic fast_pwm;
  logic pwm_mode;
  logic [7:0] top_value;
  logic at_top;
  logic count_write;
  logic flag_write;
  logic restart;
  logic ctc_clear;
  logic overflow_set;
  logic buffer_xfer;
  logic [1:0] raw_equal;
  logic [1:0] match;
  logic [1:0] force_strobe;
  logic [1:0] cmp_write;
  logic [1:0] compare_output_mode [TCW_CHANNELS];
  logic [7:0] count_plus;

  assign waveform_mode = ctrl_reg[TCW_WM_LSB +: 3];
  assign compare_output_mode[0] = ctrl_reg[TCW_MODE_A_LSB +: 2];
  assign compare_output_mode[1] = ctrl_reg[TCW_MODE_B_LSB +: 2];
  // Of the control fields only the waveform mode feeds the counter; the output modes never do.
  assign fast_pwm = (waveform_mode == TCW_WM_FAST_MAX) || (waveform_mode == TCW_WM_FAST_CMP); // [RQ8] [RQ15]
  // Odd codes are the PWM family; the dual-slope ones count like normal here.
  assign pwm_mode = waveform_mode[0];
  assign top_value = (waveform_mode == TCW_WM_FAST_CMP) ? cmp_act_reg[0] : TCW_COUNT_MAX; // [RQ15]
  assign at_top = timer_count_reg == top_value;
  assign count_plus = timer_count_reg + TCW_COUNT_STEP;
  assign count_write = reg_wr && (reg_addr == TCW_COUNT_OFF);
  assign flag_write = reg_wr && (reg_addr == TCW_FLAG_OFF);
  assign cmp_write[0] = reg_wr && (reg_addr == TCW_CMPA_OFF);
  assign cmp_write[1] = reg_wr && (reg_addr == TCW_CMPB_OFF);
  assign restart = timer_tick && fast_pwm && at_top; // [RQ16]
  assign ctc_clear = timer_tick && (waveform_mode == TCW_WM_CLEAR_ON_MATCH) && raw_equal[0]; // [RQ11]
  assign buffer_xfer = timer_tick && pwm_mode && at_top; // [RQ24]

  // ----------------------------------------
  // Comparators
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < TCW_CHANNELS; g++)
    begin : g_ch
      tcw_ch_if chi();
      assign raw_equal[g] = timer_count_reg == cmp_act_reg[g];
      // A fresh count write blanks the next tick's match on every channel.
      assign match[g] = timer_tick && raw_equal[g] && !block_reg; // [RQ1]
      assign force_strobe[g] = reg_wr && (reg_addr == TCW_FORCE_OFF) && reg_wdata[g] && !pwm_mode; // [RQ5] [RQ23]
      assign chi.match = match[g];
      assign chi.restart = restart;
      assign chi.force_strobe = force_strobe[g];
      assign chi.pwm = pwm_mode;
      assign chi.ch_a = (g == 0);
      assign chi.mode = compare_output_mode[g]; // [RQ4]
      assign chi.port_value = port_value[g];
      assign chi.direction = output_pin_direction[g];
      assign compare_output[g] = chi.pin_out;
      assign compare_output_oe[g] = chi.pin_oe;
      tcw_channel u_channel (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .ch(chi)
      );

      always_comb
      begin
        cmp_buf_next[g] = cmp_buf_reg[g];
        cmp_act_next[g] = cmp_act_reg[g];
        if (cmp_write[g])
          cmp_buf_next[g] = reg_wdata;
        if (cmp_write[g] && !pwm_mode)
          cmp_act_next[g] = reg_wdata; // [RQ12]
        else if (buffer_xfer)
          cmp_act_next[g] = cmp_buf_reg[g]; // [RQ19] [RQ24]
        // The flag follows the match by one tick; a clear loses to a set.
        pend_next[g] = match[g] ? 1'b1 : (timer_tick ? 1'b0 : pend_reg[g]);
        cmp_flag_next[g] = cmp_flag_reg[g];
        if ((flag_write && reg_wdata[TCW_CMP_BIT0 + g]) || flag_ack_compare[g])
          cmp_flag_next[g] = 1'b0; // [RQ22]
        if (timer_tick && pend_reg[g])
          cmp_flag_next[g] = 1'b1; // [RQ22]
      end

      always_ff @(posedge sys_clk)
      begin
        if (sys_rst)
        begin
          cmp_buf_reg[g] <= TCW_BYTE_RST;
          cmp_act_reg[g] <= TCW_BYTE_RST;
          pend_reg[g] <= TCW_BIT_RST;
          cmp_flag_reg[g] <= TCW_BIT_RST;
        end
        else
        begin
          cmp_buf_reg[g] <= cmp_buf_next[g];
          cmp_act_reg[g] <= cmp_act_next[g];
          pend_reg[g] <= pend_next[g];
          cmp_flag_reg[g] <= cmp_flag_next[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // Fast PWM flags the tick that reaches top; the others flag the wrap to zero.
  assign overflow_set = timer_tick && !count_write &&
    (fast_pwm ? (!restart && count_plus == top_value) : at_top); // [RQ10] [RQ14] [RQ18]

  always_comb
  begin
    timer_count_next = timer_count_reg;
    block_next = block_reg;
    if (count_write)
    begin
      timer_count_next = reg_wdata; // [RQ9]
      block_next = 1'b1; // [RQ1]
    end
    else if (timer_tick)
    begin
      block_next = 1'b0;
      if (restart || ctc_clear)
        timer_count_next = TCW_COUNT_BOTTOM; // [RQ11] [RQ16]
      else
        timer_count_next = count_plus; // [RQ9] [RQ12]
    end
  end

  always_comb
  begin
    overflow_flag_next = overflow_flag_reg;
    if ((flag_write && reg_wdata[TCW_OVF_BIT]) || flag_ack_overflow)
      overflow_flag_next = 1'b0;
    if (overflow_set)
      overflow_flag_next = 1'b1; // [RQ10]
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      timer_count_reg <= TCW_BYTE_RST;
      block_reg <= TCW_BIT_RST;
      overflow_flag_reg <= TCW_BIT_RST;
    end
    else
    begin
      timer_count_reg <= timer_count_next;
      block_reg <= block_next;
      overflow_flag_reg <= overflow_flag_next;
    end
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (reg_wr && (reg_addr == TCW_CTRL_OFF))
      ctrl_next = reg_wdata;
    rdata_next = TCW_BYTE_RST;
    if (reg_rd)
    begin
      case (reg_addr)
        TCW_CTRL_OFF: rdata_next = ctrl_reg;
        TCW_COUNT_OFF: rdata_next = timer_count_reg;
        TCW_CMPA_OFF: rdata_next = cmp_buf_reg[0];
        TCW_CMPB_OFF: rdata_next = cmp_buf_reg[1];
        TCW_FLAG_OFF: rdata_next = {5'h00, cmp_flag_reg, overflow_flag_reg};
        default: rdata_next = TCW_BYTE_RST;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ctrl_reg <= TCW_BYTE_RST; // [RQ25]
      rdata_reg <= TCW_BYTE_RST;
    end
    else
    begin
      ctrl_reg <= ctrl_next; // [RQ3]
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign overflow_flag = overflow_flag_reg;
  assign compare_flag = cmp_flag_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence count_write_s;
    count_write;
  endsequence

  sequence blocked_tick_s;
    block_reg && timer_tick;
  endsequence

  sequence match_then_tick_s;
    match[0] ##1 (timer_tick && !flag_write && !flag_ack_compare[0]);
  endsequence

  count_block_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ1]
    count_write_s ##1 blocked_tick_s |-> match == 2'b00)
    else $error("Match seen in the tick after a count write.");
  block_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ1]
    count_write_s |=> block_reg)
    else $error("Count write did not arm the match blocker.");
  compare_flag_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ22]
    match_then_tick_s |=> cmp_flag_reg[0])
    else $error("Compare flag not set on the tick after a match.");
  normal_wrap_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ9]
    timer_tick && !count_write && waveform_mode == TCW_WM_NORMAL && timer_count_reg == 8'hFF
    |=> timer_count_reg == 8'h00 && overflow_flag_reg)
    else $error("Normal mode wrap or overflow flag wrong.");
  ctc_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ11]
    timer_tick && !count_write && waveform_mode == TCW_WM_CLEAR_ON_MATCH && raw_equal[0]
    |=> timer_count_reg == 8'h00)
    else $error("Clear-on-match did not clear the count.");
  fast_restart_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ16]
    timer_tick && !count_write && fast_pwm && at_top |=> timer_count_reg == 8'h00)
    else $error("Fast PWM did not restart after top.");
  buffer_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ19]
    pwm_mode && !buffer_xfer |=> $stable(cmp_act_reg[0]) && $stable(cmp_act_reg[1]))
    else $error("Active compare changed away from top in PWM.");
  direct_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ12]
    cmp_write[0] && !pwm_mode |=> cmp_act_reg[0] == $past(reg_wdata))
    else $error("Compare A write did not reach the comparator directly.");
  force_no_flag_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ23]
    force_strobe != 2'b00 && !timer_tick && !count_write
    |=> $stable(timer_count_reg) && $stable(pend_reg))
    else $error("Force strobe disturbed the counter or flags.");
  fast_ovf_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ18]
    timer_tick && !count_write && fast_pwm && !at_top && count_plus == top_value
    |=> overflow_flag_reg)
    else $error("Fast PWM overflow flag missing at top.");

  // ----------------------------------------
  // Flag and counter checks
  // ----------------------------------------
  sequence ovf_clear_s;
    (flag_write && reg_wdata[TCW_OVF_BIT]) || flag_ack_overflow;
  endsequence

  sequence flag_a_set_s;
    timer_tick && pend_reg[0];
  endsequence

  block_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ1]
    block_reg && timer_tick && !count_write |=> !block_reg)
    else $error("Match blocker outlived its tick.");
  ovf_set_wins_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ10]
    overflow_set |=> overflow_flag_reg)
    else $error("Overflow flag lost to a clear.");
  ovf_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ10]
    !overflow_set && !flag_write && !flag_ack_overflow |=> $stable(overflow_flag_reg))
    else $error("Overflow flag moved with no set or clear.");
  ovf_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ10]
    ovf_clear_s ##0 !overflow_set |=> !overflow_flag_reg)
    else $error("Overflow flag survived a clear.");
  flag_a_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ22]
    flag_a_set_s |=> cmp_flag_reg[0])
    else $error("Compare flag A not set by its match.");
  flag_a_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ22]
    flag_ack_compare[0] && !(timer_tick && pend_reg[0]) |=> !cmp_flag_reg[0])
    else $error("Compare flag A survived an acknowledge.");
  flag_a_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ22]
    !(timer_tick && pend_reg[0]) && !flag_write && !flag_ack_compare[0]
    |=> $stable(cmp_flag_reg[0]))
    else $error("Compare flag A moved with no set or clear.");
  write_wins_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ9]
    count_write |=> timer_count_reg == $past(reg_wdata))
    else $error("Count write did not win over counting.");
  count_step_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ8] [RQ9]
    timer_tick && !count_write && !restart && !ctc_clear
    |=> timer_count_reg == 8'($past(timer_count_reg) + TCW_COUNT_STEP))
    else $error("Counter did not step by one.");
  ctc_ovf_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ14]
    timer_tick && !count_write && waveform_mode == TCW_WM_CLEAR_ON_MATCH
    && timer_count_reg == TCW_COUNT_MAX |=> overflow_flag_reg)
    else $error("Clear-on-match overflow missing at the wrap.");
  xfer_top_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ24]
    buffer_xfer |=> cmp_act_reg[0] == $past(cmp_buf_reg[0])
    && cmp_act_reg[1] == $past(cmp_buf_reg[1]))
    else $error("Buffered compare not moved at top.");
  fast_max_top_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ15]
    timer_tick && !count_write && waveform_mode == TCW_WM_FAST_MAX
    && timer_count_reg == TCW_COUNT_MAX |=> timer_count_reg == TCW_COUNT_BOTTOM)
    else $error("Fixed-top fast PWM did not restart.");
  fast_cmp_top_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RQ15]
    timer_tick && !count_write && waveform_mode == TCW_WM_FAST_CMP
    && timer_count_reg == cmp_act_reg[0] |=> timer_count_reg == TCW_COUNT_BOTTOM)
    else $error("Compare-top fast PWM did not restart.");
endmodule // tcw_timer

/* sim/tcw_pin_load.sv */
module tcw_pin_load
(
  input wire logic [1:0] drive,
  input wire logic [1:0] drive_en,
  output logic [1:0] pad
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Pin load
  // ----------------------------------------
  // The board pulls each pin low, so a pin left undriven never shows a stale level.
  assign pad = drive & drive_en;
endmodule // tcw_pin_load

/* sim/test_timer_compare_waveform_unit.sv */
module test_timer_compare_waveform_unit
  import tcw_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic timer_tick = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic flag_ack_overflow = 1'b0;
  logic [1:0] flag_ack_compare = 2'h0;
  logic [1:0] port_value = 2'h0;
  logic [1:0] output_pin_direction = 2'h3;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [1:0] compare_output;
  logic [1:0] compare_output_oe;
  logic [1:0] compare_flag;
  logic [1:0] pad;
  logic overflow_flag;
  logic [7:0] c;
  logic e;
  int n;
  int errors = 0;
  int checked = 0;
  int seed = 74;

  tcw_timer i_dut (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .timer_tick(timer_tick),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .flag_ack_overflow(flag_ack_overflow),
    .flag_ack_compare(flag_ack_compare),
    .port_value(port_value),
    .output_pin_direction(output_pin_direction),
    .compare_output(compare_output),
    .compare_output_oe(compare_output_oe),
    .overflow_flag(overflow_flag),
    .compare_flag(compare_flag)
  );

  tcw_pin_load i_load (
    .drive(compare_output),
    .drive_en(compare_output_oe),
    .pad(pad)
  );

  initial
  begin
    forever #2 sys_clk = ~sys_clk;
  end
  // ----------------------------------------
  // Expectations and bus tasks
  // ----------------------------------------
  function automatic logic [7:0] next_count(logic [7:0] start, int ticks);
    return start + 8'(ticks);
  endfunction

  function automatic logic next_latch(logic [1:0] mode, logic last);
    return (mode == TCW_OM_SET) ? 1'b1 : (mode == TCW_OM_CLEAR) ? 1'b0 : ~last;
  endfunction

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic tick(input int cnt);
    @(posedge sys_clk);
    timer_tick <= 1'b1;
    repeat (cnt) @(posedge sys_clk);
    timer_tick <= 1'b0;
  endtask

  task automatic ack(input logic ov, input logic [1:0] cm);
    @(posedge sys_clk);
    flag_ack_overflow <= ov;
    flag_ack_compare <= cm;
    @(posedge sys_clk);
    flag_ack_overflow <= 1'b0;
    flag_ack_compare <= 2'h0;
  endtask

  task automatic settle;
    @(posedge sys_clk);
    #1;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    port_value <= 2'($random(seed));
    output_pin_direction <= 2'($random(seed));
    rdchk(TCW_CTRL_OFF, 8'h00);
    rdchk(TCW_COUNT_OFF, 8'h00);
    rdchk(TCW_FLAG_OFF, 8'h00);
    chk({6'h00, compare_output}, {6'h00, port_value});
    chk({6'h00, pad}, {6'h00, port_value & output_pin_direction});
    wr(TCW_CTRL_OFF, 8'h40);
    settle;
    chk1(compare_output[0], 1'b0);
    wr(TCW_CTRL_OFF, 8'h00);
    @(posedge sys_clk);
    port_value <= 2'h0;
    output_pin_direction <= 2'h3;
    wr(TCW_CMPA_OFF, 8'h05);
    wr(TCW_COUNT_OFF, 8'hFE);
    tick(1);
    rdchk(TCW_COUNT_OFF, 8'hFF);
    chk1(overflow_flag, 1'b0);
    tick(1);
    rdchk(TCW_COUNT_OFF, 8'h00);
    chk1(overflow_flag, 1'b1);
    ack(1'b1, 2'h0);
    settle;
    chk1(overflow_flag, 1'b0);
    wr(TCW_COUNT_OFF, 8'h05);
    tick(3);
    settle;
    chk({6'h00, compare_flag}, 8'h00);
    wr(TCW_COUNT_OFF, 8'h04);
    tick(3);
    settle;
    chk1(compare_flag[0], 1'b1);
    ack(1'b0, 2'h1);
    settle;
    chk1(compare_flag[0], 1'b0);
    e = 1'b0;
    for (int m = 3; m > 0; m--)
    begin
      wr(TCW_CTRL_OFF, {2'(m), 2'(m), 4'h0});
      wr(TCW_FORCE_OFF, 8'h03);
      settle;
      e = next_latch(2'(m), e);
      chk({6'h00, compare_output}, {6'h00, e, e});
    end
    chk({6'h00, compare_flag}, 8'h00);
    rdchk(TCW_COUNT_OFF, 8'h07);
    wr(TCW_CTRL_OFF, 8'h83);
    wr(TCW_FORCE_OFF, 8'h01);
    settle;
    chk1(compare_output[0], 1'b1);
    wr(TCW_CTRL_OFF, 8'h03);
    settle;
    chk1(compare_output[0], port_value[0]);
    wr(TCW_CTRL_OFF, 8'h42);
    wr(TCW_CMPA_OFF, 8'h02);
    wr(TCW_COUNT_OFF, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      tick(3);
      rdchk(TCW_COUNT_OFF, 8'h00);
      e = ~e;
      chk1(compare_output[0], e);
    end
    wr(TCW_FLAG_OFF, 8'h07);
    wr(TCW_COUNT_OFF, 8'hFD);
    tick(3);
    settle;
    chk1(overflow_flag, 1'b1);
    chk1(compare_output[0], e);
    tick(3);
    settle;
    chk1(compare_output[0], ~e);
    wr(TCW_CTRL_OFF, 8'h02);
    tick(3);
    wr(TCW_CTRL_OFF, 8'hC2);
    settle;
    chk1(compare_output[0], ~e);
    tick(3);
    settle;
    chk1(compare_output[0], 1'b1);
    wr(TCW_CTRL_OFF, 8'hC3);
    wr(TCW_FLAG_OFF, 8'h07);
    wr(TCW_COUNT_OFF, 8'hF0);
    wr(TCW_CMPA_OFF, 8'h10);
    rdchk(TCW_CMPA_OFF, 8'h10);
    tick(15);
    settle;
    chk1(overflow_flag, 1'b1);
    tick(1);
    rdchk(TCW_COUNT_OFF, 8'h00);
    chk1(compare_output[0], 1'b0);
    tick(16);
    settle;
    chk1(compare_output[0], 1'b0);
    tick(1);
    settle;
    chk1(compare_output[0], 1'b1);
    wr(TCW_CTRL_OFF, 8'h83);
    tick(256);
    settle;
    chk1(compare_output[0], 1'b0);
    wr(TCW_CTRL_OFF, 8'h87);
    wr(TCW_COUNT_OFF, 8'h0E);
    tick(2);
    rdchk(TCW_COUNT_OFF, 8'h10);
    tick(1);
    rdchk(TCW_COUNT_OFF, 8'h00);
    wr(TCW_CTRL_OFF, 8'h83);
    wr(TCW_CMPA_OFF, 8'hFF);
    tick(256);
    for (int i = 0; i < 32; i++)
    begin
      tick(8);
      settle;
      chk1(compare_output[0], 1'b1);
    end
    wr(TCW_CTRL_OFF, 8'h00);
    for (int i = 0; i < 24; i++)
    begin
      c = 8'($random(seed));
      n = 1 + ($random(seed) & 7);
      @(posedge sys_clk);
      port_value <= 2'($random(seed));
      output_pin_direction <= 2'($random(seed));
      wr(TCW_COUNT_OFF, c);
      tick(n);
      rdchk(TCW_COUNT_OFF, next_count(c, n));
      chk({6'h00, compare_output}, {6'h00, port_value});
      chk({6'h00, compare_output_oe}, {6'h00, output_pin_direction});
    end
    conclude;
  end

  // The whole sequence needs 1200 to 1400 cycles; this leaves ample margin.
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    conclude;
  end
endmodule // test_timer_compare_waveform_unit
